// ==== pcr_pkg.sv ====
package pcr_pkg;

    // ====================================================================
    // register map (byte addresses)
    localparam logic [3:0]  ADDR_POCTL    = 4'h0;
    localparam logic [3:0]  ADDR_STATUS   = 4'h4;
    localparam logic [3:0]  ADDR_MASK     = 4'h8;
    localparam int          ADDR_W        = 4;

    // ====================================================================
    // protocol_operation_control fields
    localparam int          CORR_WME_BIT  = 15;
    localparam int          OFS_HI        = 11;
    localparam int          OFS_LO        = 10;
    localparam int          RATE_HI       = 9;
    localparam int          RATE_LO       = 8;
    localparam int          BUSY_BIT      = 7;
    localparam int          CMD_HI        = 3;
    localparam int          CMD_LO        = 0;
    localparam int          LANE_CORR     = 1;
    localparam int          LANE_CMD      = 0;

    localparam logic       WRITE_MODE_ON  = 1'h0;
    localparam logic [1:0] CORR_RST       = 2'h0;
    localparam logic [3:0] CMD_RST        = 4'h0;

    // ====================================================================
    // status / mask bits
    localparam int          ST_W          = 2;
    localparam int          ST_IGNORED    = 0;
    localparam int          ST_ACCEPTED   = 1;
    localparam logic [1:0]  ST_RST        = 2'h0;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_DECERR   = 2'h3;

    // ====================================================================
    // protocol commands
    typedef enum logic [3:0] {
        CMD_ALLOW_COLDSTART = 4'h0,
        CMD_CONFIG          = 4'h2,
        CMD_ALL_SLOTS       = 4'h3,
        CMD_READY           = 4'h4,
        CMD_RUN             = 4'h5,
        CMD_DEFAULT_CONFIG  = 4'h6,
        CMD_HALT            = 4'h7,
        CMD_WAKEUP          = 4'h8,
        CMD_ENGINE_RESET    = 4'hA
    } pcr_cmd_t;

    typedef enum logic [1:0] {
        CS_IDLE  = 2'b00,
        CS_DEFER = 2'b01,
        CS_REQ   = 2'b10
    } pcr_cstate_t;

endpackage : pcr_pkg

// ==== pcr_cmd_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcr_cmd_decode (
    // command code
    input  wire logic [3:0] code_i,
    // class
    output logic            legal_o,
    output logic            delayed_o
);
    always_comb begin
        legal_o   = 1'b1;
        delayed_o = 1'b0;
        unique case (code_i)
            pcr_pkg::CMD_ALLOW_COLDSTART, pcr_pkg::CMD_CONFIG, pcr_pkg::CMD_READY,
            pcr_pkg::CMD_RUN, pcr_pkg::CMD_DEFAULT_CONFIG, pcr_pkg::CMD_WAKEUP,
            pcr_pkg::CMD_ENGINE_RESET: begin
                legal_o = 1'b1; // [R9]
            end
            pcr_pkg::CMD_ALL_SLOTS, pcr_pkg::CMD_HALT: begin
                delayed_o = 1'b1; // [R10]
            end
            default: begin
                legal_o = 1'b0; // [R9]
            end
        endcase
    end
endmodule : pcr_cmd_decode
`default_nettype wire

// ==== pcr_protocol_op_control.sv ====
// How it works
// [R1] Bit 15 of a register write decides whether the two correction apply fields take new values.
// [R2] Bit 15 at zero lets the correction fields update, at one leaves them as they were.
// [R3] Both correction apply fields read back the value last written into them.
// [R4] Offset apply field 11:10 means 00 none, 10 subtract, 11 add; software never writes 01.
// [R5] Rate apply field 9:8 means 00 none, 10 subtract, 11 add; software never writes 01.
// [R6] A command field write issues a protocol command; a correction field write is a correction command.
// [R7] Busy (bit 7) sets on a command write, clears on engine accept; a write while busy is dropped and flagged.
// [R8] Bit 7 written as zero stores the command, written as one leaves the command field alone.
// [R9] The command field decodes nine commands; the remaining codes are reserved.
// [R10] Halt and all-slots reach the engine only when the current communication cycle ends.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pcr_protocol_op_control (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // axi4-lite write
    input  wire logic [3:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // axi4-lite read
    input  wire logic [3:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // protocol engine
    output logic             cmd_req_o,
    output logic [3:0]       cmd_code_o,
    input  wire logic        cmd_accept_i,
    input  wire logic        cycle_end_i,
    // clock correction
    output logic [1:0]       offset_corr_apply_o,
    output logic [1:0]       rate_corr_apply_o,
    output logic             corr_cmd_strobe_o,
    // interrupt
    output logic             irq_o
);
    // ====================================================================
    // state
    logic              awready_r, awready_nxt, wready_r, wready_nxt, req_r, req_nxt;
    logic              bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [1:0]        ofs_r, ofs_nxt, rate_r, rate_nxt;
    logic [3:0]        cmd_r, cmd_nxt;
    logic              busy_r, busy_nxt, strobe_r, strobe_nxt, irq_r, irq_nxt;
    logic [1:0]        st_r, st_nxt, mask_r, mask_nxt;
    pcr_pkg::pcr_cstate_t cs_r, cs_nxt;
    logic              ce_meta_r, ce_sync_r, ce_prev_r;
    logic              legal, delayed, wr_go, rd_go, ce_rise, cmd_wr, cmd_ignored;
    logic [31:0]       ctl_view;

    pcr_cmd_decode pcr_cmd_decode_i (
        .code_i    (s_axi_wdata_i[pcr_pkg::CMD_HI:pcr_pkg::CMD_LO]),
        .legal_o   (legal),
        .delayed_o (delayed)
    );

    // ====================================================================
    // cycle-end pin synchroniser; edge taken from the second stage only
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ce_meta_r <= 1'b0;
            ce_sync_r <= 1'b0;
            ce_prev_r <= 1'b0;
        end else begin
            ce_meta_r <= cycle_end_i;
            ce_sync_r <= ce_meta_r;
            ce_prev_r <= ce_sync_r;
        end
    end
    assign ce_rise = ce_sync_r & ~ce_prev_r;

    // ====================================================================
    // next-state logic
    always_comb begin
        ctl_view = '0;
        ctl_view[pcr_pkg::OFS_HI:pcr_pkg::OFS_LO]   = ofs_r;  // [R3]
        ctl_view[pcr_pkg::RATE_HI:pcr_pkg::RATE_LO] = rate_r; // [R3]
        ctl_view[pcr_pkg::BUSY_BIT]                 = busy_r;
        ctl_view[pcr_pkg::CMD_HI:pcr_pkg::CMD_LO]   = cmd_r;

        // both channels taken in one cycle; a pending response holds off the next write
        wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_r & ~awready_r;
        rd_go = s_axi_arvalid_i & ~rvalid_r & ~arready_r;
        awready_nxt = wr_go;
        wready_nxt  = wr_go;
        arready_nxt = rd_go;
        bvalid_nxt  = (bvalid_r & ~s_axi_bready_i) | wr_go;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = (rvalid_r & ~s_axi_rready_i) | rd_go;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;

        ofs_nxt    = ofs_r;
        rate_nxt   = rate_r;
        cmd_nxt    = cmd_r;
        busy_nxt   = busy_r;
        cs_nxt     = cs_r;
        strobe_nxt = 1'b0;
        mask_nxt   = mask_r;
        st_nxt     = st_r;
        cmd_wr      = 1'b0;
        cmd_ignored = 1'b0;

        // engine handshake
        unique case (cs_r)
            pcr_pkg::CS_IDLE: begin
                cs_nxt = pcr_pkg::CS_IDLE;
            end
            pcr_pkg::CS_DEFER: begin
                if (ce_rise) begin
                    cs_nxt = pcr_pkg::CS_REQ; // [R10]
                end
            end
            pcr_pkg::CS_REQ: begin
                if (cmd_accept_i) begin
                    cs_nxt   = pcr_pkg::CS_IDLE;
                    busy_nxt = 1'b0; // [R7]
                end
            end
            default: begin
                cs_nxt = pcr_pkg::CS_IDLE;
            end
        endcase

        if (wr_go) begin
            bresp_nxt = pcr_pkg::RESP_OKAY;
            unique case (s_axi_awaddr_i)
                pcr_pkg::ADDR_POCTL: begin
                    // a missing upper byte lane counts as "no write" for the corrections
                    if (s_axi_wstrb_i[pcr_pkg::LANE_CORR] &&
                        s_axi_wdata_i[pcr_pkg::CORR_WME_BIT] == pcr_pkg::WRITE_MODE_ON) begin // [R1] [R2]
                        ofs_nxt    = s_axi_wdata_i[pcr_pkg::OFS_HI:pcr_pkg::OFS_LO];   // [R4]
                        rate_nxt   = s_axi_wdata_i[pcr_pkg::RATE_HI:pcr_pkg::RATE_LO]; // [R5]
                        strobe_nxt = 1'b1; // [R6]
                    end
                    cmd_wr = s_axi_wstrb_i[pcr_pkg::LANE_CMD] &&
                             s_axi_wdata_i[pcr_pkg::BUSY_BIT] == pcr_pkg::WRITE_MODE_ON; // [R8]
                    if (cmd_wr && busy_r) begin
                        cmd_ignored = 1'b1; // [R7]
                    end else if (cmd_wr && legal) begin
                        cmd_nxt  = s_axi_wdata_i[pcr_pkg::CMD_HI:pcr_pkg::CMD_LO]; // [R6]
                        busy_nxt = 1'b1; // [R7]
                        cs_nxt   = delayed ? pcr_pkg::CS_DEFER : pcr_pkg::CS_REQ; // [R10]
                    end
                end
                pcr_pkg::ADDR_STATUS: begin
                    st_nxt = st_nxt & ~s_axi_wdata_i[pcr_pkg::ST_W-1:0];
                end
                pcr_pkg::ADDR_MASK: begin
                    mask_nxt = s_axi_wdata_i[pcr_pkg::ST_W-1:0];
                end
                default: begin
                    bresp_nxt = pcr_pkg::RESP_DECERR;
                end
            endcase
        end
        // hardware set wins over a same-cycle clear
        if (cmd_ignored) begin
            st_nxt[pcr_pkg::ST_IGNORED] = 1'b1; // [R7]
        end
        if (cs_r == pcr_pkg::CS_REQ && cmd_accept_i) begin
            st_nxt[pcr_pkg::ST_ACCEPTED] = 1'b1;
        end

        if (rd_go) begin
            rresp_nxt = pcr_pkg::RESP_OKAY;
            unique case (s_axi_araddr_i)
                pcr_pkg::ADDR_POCTL: begin
                    rdata_nxt = ctl_view;
                end
                pcr_pkg::ADDR_STATUS: begin
                    rdata_nxt = {30'h0, st_r};
                end
                pcr_pkg::ADDR_MASK: begin
                    rdata_nxt = {30'h0, mask_r};
                end
                default: begin
                    rdata_nxt = '0;
                    rresp_nxt = pcr_pkg::RESP_DECERR;
                end
            endcase
        end
        req_nxt = (cs_nxt == pcr_pkg::CS_REQ);
        irq_nxt = |(st_nxt & mask_nxt);
    end

    // ====================================================================
    // registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= pcr_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= pcr_pkg::RESP_OKAY;
            rdata_r   <= '0;
            ofs_r     <= pcr_pkg::CORR_RST;
            rate_r    <= pcr_pkg::CORR_RST;
            cmd_r     <= pcr_pkg::CMD_RST;
            busy_r    <= 1'b0;
            cs_r      <= pcr_pkg::CS_IDLE;
            strobe_r  <= 1'b0;
            st_r      <= pcr_pkg::ST_RST;
            mask_r    <= pcr_pkg::ST_RST;
            irq_r     <= 1'b0;
            req_r     <= 1'b0;
        end else begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            ofs_r     <= ofs_nxt;
            rate_r    <= rate_nxt;
            cmd_r     <= cmd_nxt;
            busy_r    <= busy_nxt;
            cs_r      <= cs_nxt;
            strobe_r  <= strobe_nxt;
            st_r      <= st_nxt;
            mask_r    <= mask_nxt;
            irq_r     <= irq_nxt;
            req_r     <= req_nxt;
        end
    end

    assign s_axi_awready_o     = awready_r;
    assign s_axi_wready_o      = wready_r;
    assign s_axi_bvalid_o      = bvalid_r;
    assign s_axi_bresp_o       = bresp_r;
    assign s_axi_arready_o     = arready_r;
    assign s_axi_rvalid_o      = rvalid_r;
    assign s_axi_rresp_o       = rresp_r;
    assign s_axi_rdata_o       = rdata_r;
    assign cmd_req_o           = req_r;
    assign cmd_code_o          = cmd_r;
    assign offset_corr_apply_o = ofs_r;
    assign rate_corr_apply_o   = rate_r;
    assign corr_cmd_strobe_o   = strobe_r;
    assign irq_o               = irq_r;

    // ====================================================================
    // checks
    a_corr_hold_wme: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R1]
        (wr_go && s_axi_wdata_i[pcr_pkg::CORR_WME_BIT]) |=> $stable(ofs_r) && $stable(rate_r))
        else $error("correction fields changed with write mode off");
    a_corr_write_on: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R2]
        (wr_go && s_axi_awaddr_i == pcr_pkg::ADDR_POCTL && s_axi_wstrb_i[pcr_pkg::LANE_CORR]
         && !s_axi_wdata_i[pcr_pkg::CORR_WME_BIT])
        |=> offset_corr_apply_o == $past(s_axi_wdata_i[pcr_pkg::OFS_HI:pcr_pkg::OFS_LO])
            && rate_corr_apply_o == $past(s_axi_wdata_i[pcr_pkg::RATE_HI:pcr_pkg::RATE_LO])
            && corr_cmd_strobe_o)
        else $error("correction fields not written");
    a_ofs_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R3] [R4] [R5]
        (rd_go && s_axi_araddr_i == pcr_pkg::ADDR_POCTL)
        |=> s_axi_rdata_o[pcr_pkg::OFS_HI:pcr_pkg::RATE_LO] == {$past(ofs_r), $past(rate_r)})
        else $error("correction readback wrong");
    a_busy_ignore: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7]
        (wr_go && cmd_wr && busy_r) |=> $stable(cmd_r) && st_r[pcr_pkg::ST_IGNORED])
        else $error("busy write not ignored");
    a_busy_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7]
        (cmd_req_o && cmd_accept_i) |=> !busy_r && !cmd_req_o)
        else $error("busy not cleared on accept");
    a_cmd_issue: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R6] [R8]
        (wr_go && cmd_wr && !busy_r && legal && !delayed) |=> cmd_req_o && busy_r)
        else $error("command not issued");
    a_cmd_hold_wmc: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R8]
        (wr_go && !cmd_wr && cs_r == pcr_pkg::CS_IDLE) |=> $stable(cmd_r) && !cmd_req_o)
        else $error("command stored with write mode off");
    a_reserved_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R9]
        (wr_go && cmd_wr && !legal) |=> $stable(cmd_r))
        else $error("reserved command stored");
    a_delay_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R10]
        (cs_r == pcr_pkg::CS_DEFER && !ce_rise) |=> !cmd_req_o)
        else $error("delayed command issued early");
    a_irq_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        irq_o == |(st_r & mask_r))
        else $error("interrupt missing");
endmodule : pcr_protocol_op_control
`default_nettype wire

// ==== pcr_protocol_op_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcr_protocol_op_control_tb;

    // ====================================================================
    // stimulus and observed signals
    logic        ref_clk_i, rst_i;
    logic [3:0]  awaddr, araddr, wstrb;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata, rdata;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, ofs_ap, rate_ap;
    logic        cmd_req, cmd_accept_i, cycle_end_i, strobe, irq;
    logic [3:0]  cmd_code;
    int          n_errors, total_checks, n_strobe, cyc;
    logic [1:0]  r;
    logic [31:0] d;

    pcr_protocol_op_control pcr_protocol_op_control_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .cmd_req_o(cmd_req),
        .cmd_code_o(cmd_code), .cmd_accept_i(cmd_accept_i), .cycle_end_i(cycle_end_i),
        .offset_corr_apply_o(ofs_ap), .rate_corr_apply_o(rate_ap),
        .corr_cmd_strobe_o(strobe), .irq_o(irq));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // ====================================================================
    // hang guard and strobe counter
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (strobe === 1'b1) n_strobe <= n_strobe + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // ====================================================================
    // bus master; waits are bounded, a stuck slave counts as a mismatch
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        @(posedge ref_clk_i);
        awaddr <= a; wdata <= v; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (n == 50) chk("bvalid", 1, 0);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        int n;
        @(posedge ref_clk_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk_i);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata; r = rresp;
        rready <= 1'b0;
        if (n == 50) chk("rvalid", 1, 0);
    endtask : rd

    task automatic accept();
        @(posedge ref_clk_i) cmd_accept_i <= 1'b1;
        @(posedge ref_clk_i) cmd_accept_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : accept

    // ====================================================================
    // scenarios
    task automatic t_corr();
        int s0;
        rd(pcr_pkg::ADDR_POCTL); chk("ctl reset", 32'h0, d);
        s0 = n_strobe;
        wr(pcr_pkg::ADDR_POCTL, 32'h0000_0E80, 4'h3);
        chk("bresp ok", pcr_pkg::RESP_OKAY, r);
        rd(pcr_pkg::ADDR_POCTL); chk("ctl corr", 32'h0000_0E00, d);
        chk("rresp ok", pcr_pkg::RESP_OKAY, r);
        chk("ofs out", 2'h3, ofs_ap);
        chk("rate out", 2'h2, rate_ap);
        chk("strobe", s0 + 1, n_strobe);
        wr(pcr_pkg::ADDR_POCTL, 32'h0000_8B80, 4'h3);
        rd(pcr_pkg::ADDR_POCTL); chk("ctl kept", 32'h0000_0E00, d);
        chk("strobe kept", s0 + 1, n_strobe);
        wr(pcr_pkg::ADDR_POCTL, 32'h0000_0B80, 4'h3);
        rd(pcr_pkg::ADDR_POCTL); chk("ctl corr2", 32'h0000_0B00, d);
        chk("ofs sub", 2'h2, ofs_ap);
        chk("rate add", 2'h3, rate_ap);
        $display("test correction done");
    endtask : t_corr

    task automatic t_busy();
        wr(pcr_pkg::ADDR_MASK, 32'h2, 4'hF);
        wr(pcr_pkg::ADDR_POCTL, 32'h0000_0005, 4'h1);
        chk("req", 1, cmd_req);
        chk("code", 4'h5, cmd_code);
        wr(pcr_pkg::ADDR_POCTL, 32'h0000_0004, 4'h1);
        rd(pcr_pkg::ADDR_POCTL); chk("ctl busy", 32'h0000_0B85, d);
        rd(pcr_pkg::ADDR_STATUS); chk("st ignored", 32'h1, d);
        chk("irq masked", 0, irq);
        accept();
        rd(pcr_pkg::ADDR_POCTL); chk("ctl idle", 32'h0000_0B05, d);
        rd(pcr_pkg::ADDR_STATUS); chk("st accepted", 32'h3, d);
        chk("irq", 1, irq);
        wr(pcr_pkg::ADDR_STATUS, 32'h3, 4'hF);
        @(posedge ref_clk_i);
        chk("irq clr", 0, irq);
        wr(pcr_pkg::ADDR_POCTL, 32'h0000_0086, 4'h1);
        chk("mode off", 0, cmd_req);
        $display("test busy done");
    endtask : t_busy

    task automatic t_codes();
        logic [3:0] c[7] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA};
        foreach (c[i]) begin
            wr(pcr_pkg::ADDR_POCTL, {28'h0, c[i]}, 4'h1);
            chk("imm req", 1, cmd_req);
            chk("imm code", c[i], cmd_code);
            accept();
            chk("imm done", 0, cmd_req);
        end
        wr(pcr_pkg::ADDR_POCTL, 32'h9, 4'h1);
        chk("rsv req", 0, cmd_req);
        wr(pcr_pkg::ADDR_POCTL, 32'hF, 4'h1);
        rd(pcr_pkg::ADDR_POCTL); chk("rsv busy", 0, d[7]);
        $display("test codes done");
    endtask : t_codes

    task automatic t_delayed();
        logic [3:0] c[2] = '{4'h3, 4'h7};
        int n;
        foreach (c[i]) begin
            wr(pcr_pkg::ADDR_POCTL, {28'h0, c[i]}, 4'h1);
            repeat (6) @(posedge ref_clk_i);
            chk("early req", 0, cmd_req);
            rd(pcr_pkg::ADDR_POCTL); chk("dly busy", 1, d[7]);
            cycle_end_i <= 1'b1;
            for (n = 0; n < 10 && cmd_req !== 1'b1; n++) @(posedge ref_clk_i);
            chk("late req", 1, cmd_req);
            chk("late code", c[i], cmd_code);
            cycle_end_i <= 1'b0;
            accept();
        end
        $display("test delayed done");
    endtask : t_delayed

    task automatic t_unmapped();
        wr(4'hC, 32'hFFFF_FFFF, 4'hF);
        chk("bresp", pcr_pkg::RESP_DECERR, r);
        rd(4'hC); chk("rresp", pcr_pkg::RESP_DECERR, r);
        chk("rdata", 0, d);
        $display("test unmapped done");
    endtask : t_unmapped

    initial begin
        {awaddr, araddr, wstrb, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {cmd_accept_i, cycle_end_i} = '0;
        {n_errors, total_checks, n_strobe, cyc} = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_corr();
        t_busy();
        t_codes();
        t_delayed();
        t_unmapped();
        end_sim();
    end

endmodule : pcr_protocol_op_control_tb
`default_nettype wire
